// ### ebc_pkg.sv
// package: address map, bus modes and carrier types of the bus controller
package bus_ctrl_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] SEG0_END = 24'h00ffff;
    localparam logic [23:0] SYS_RAM_LO = 24'h008000;
    localparam logic [23:0] SPEC_REG_LO = 24'h00fe00;
    localparam logic [23:0] EXT_REG_LO = 24'h00f000;
    localparam logic [23:0] EXT_REG_HI = 24'h00f1ff;
    localparam logic [23:0] DUAL_RAM_LO = 24'h00f600;
    localparam logic [23:0] DUAL_RAM_HI = 24'h00fdff;
    localparam logic [23:0] DUAL_RAM_BIT_LO = 24'h00fd00;
    localparam logic [23:0] XMEM1_HI = 24'h1fffff;
    localparam logic [23:0] CAN_LO = 24'h200000;
    localparam logic [23:0] CAN_HI = 24'h2007ff;
    localparam logic [23:0] XIO_HI = 24'h3fffff;
    localparam logic [23:0] XMEM2_HI = 24'hbeffff;
    localparam logic [23:0] FLASH_LO = 24'hc00000;
    localparam logic [23:0] FLASH_HI = 24'hc1ffff;
    localparam logic [23:0] PROG_RAM_LO = 24'he00000;
    localparam logic [23:0] PROG_RAM_HI = 24'he007ff;
    localparam logic [23:0] RES_TRAP_LO = 24'hf80000;
    localparam logic [23:0] FREG_LO = 24'hfff000;
    localparam logic [23:0] FREG_DEF_HI = 24'hfff0ff;
    localparam logic [15:0] TRAP_CODE = 16'h0a5a; // arbitrary trap pattern
    localparam logic [3:0] SEGW_MAX = 4'h7;
    localparam logic [1:0] PH_ADDR_CYC = 2'h2;
    localparam logic [1:0] PH_DATA_CYC = 2'h2;

    typedef enum logic [2:0] {
        TGT_INT = 3'h0, TGT_REGS = 3'h1, TGT_LXB = 3'h2,
        TGT_EXT = 3'h3, TGT_TRAP = 3'h4, TGT_FREG = 3'h5
    } target_t;

    typedef enum logic [1:0] {
        MODE_D16_DEMUX = 2'h0, MODE_D16_MUX = 2'h1,
        MODE_D8_MUX = 2'h2, MODE_D8_DEMUX = 2'h3
    } bus_mode_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic write;
        logic word;
    } access_t;

    typedef struct packed {
        logic [23:0] base;
        logic [3:0] size_log;
        logic enable;
    } window_t;

    typedef struct packed {
        bus_mode_t mode;
        logic [1:0] wait_cyc;
        logic cs_enable;
    } region_cfg_t;
endpackage

// ### ext_bus_address_decode.sv
// address decode and external bus cycle controller
module ext_bus_address_decode
    import bus_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire access_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_trap,
    output logic rsp_bit_ok,
    output logic rsp_no_pipe,
    input wire logic single_chip,
    input wire logic [3:0] seg_lines,
    input wire window_t win_cfg [1:4],
    input wire region_cfg_t region_timing_cfg [0:4],
    input wire logic [15:0] int_rdata,
    input wire logic [15:0] lxb_rdata,
    input wire logic bus_reference_clock_out,
    output logic [15:0] address_port,
    output logic [7:0] segment_port,
    output logic [15:0] data_port_o,
    output logic [15:0] data_port_oe,
    input wire logic [15:0] data_port_i,
    output logic addr_latch_en,
    output logic rd_n,
    output logic wr_n,
    output logic [4:0] cs_n,
    output logic lxb_sel
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_DATA = 3'h2, ST_WAIT = 3'h3, ST_DONE = 3'h4
    } state_t;

    // release through two flops so every flop leaves reset on the same edge
    logic rst_s1_q, rst_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // link clock sampled through three flops, the rise found from the second and third
    logic clk_s1_q, clk_s2_q, clk_s3_q;
    logic [15:0] din_s1_q, din_s2_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
        end else begin
            clk_s1_q <= bus_reference_clock_out;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            din_s1_q <= data_port_i;
            din_s2_q <= din_s1_q;
        end
    end
    wire link_rise = clk_s2_q & ~clk_s3_q;

    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic win_hit(input logic [23:0] a, input window_t w);
        logic [23:0] m;
        m = 24'hffffff << w.size_log;
        win_hit = w.enable && ((a & m) == (w.base & m));
    endfunction

    // whole 24-bit space decoded; segment = a[23:16], page = a[15:14]
    wire [23:0] a = req.addr;
    wire is_seg0 = (a <= SEG0_END);
    wire is_regs = is_seg0 && (in_rng(a, SPEC_REG_LO, SEG0_END)
                   || in_rng(a, EXT_REG_LO, EXT_REG_HI));
    wire is_intram = is_seg0 && in_rng(a, SYS_RAM_LO, SEG0_END) && !is_regs;
    wire is_bitadr = in_rng(a, DUAL_RAM_BIT_LO, DUAL_RAM_HI) || is_regs;
    wire is_can = in_rng(a, CAN_LO, CAN_HI);
    wire is_xio = (a > CAN_HI) && (a <= XIO_HI);
    wire is_xmem = (!is_seg0 && a <= XMEM1_HI) || (a < SYS_RAM_LO)
                   || (a > XIO_HI && a <= XMEM2_HI);
    wire is_pmem = in_rng(a, FLASH_LO, FLASH_HI) || in_rng(a, PROG_RAM_LO, PROG_RAM_HI);
    // flash register holes answer with a trap pattern, never stale data
    wire is_freg = (a >= FREG_LO);
    wire freg_undef = is_freg && (a > FREG_DEF_HI);
    wire is_ext = (is_xmem || is_xio) && !single_chip;
    target_t tgt;
    assign tgt = is_ext ? TGT_EXT : is_can ? TGT_LXB : (is_regs) ? TGT_REGS
               : (is_intram || is_pmem) ? TGT_INT : is_freg ? TGT_FREG : TGT_TRAP;

    // window priority: 4 > 3 > 2 > 1, default region 0
    wire [4:1] hit = {win_hit(a, win_cfg[4]), win_hit(a, win_cfg[3]),
                      win_hit(a, win_cfg[2]), win_hit(a, win_cfg[1])};
    wire [2:0] region = hit[4] ? 3'h4 : hit[3] ? 3'h3 : hit[2] ? 3'h2 : hit[1] ? 3'h1 : 3'h0;
    region_cfg_t rcfg;
    assign rcfg = region_timing_cfg[region];
    wire [3:0] segw = (seg_lines > SEGW_MAX) ? SEGW_MAX : seg_lines;
    wire [7:0] seg_mask = 8'((9'h001 << segw) - 9'h001);

    // cnt_q counts link rises of the current phase only
    state_t st_q, st_d;
    access_t acc_q;
    region_cfg_t cfg_q;
    logic [2:0] reg_q;
    logic [1:0] cnt_q;
    logic nopipe_q;

    wire is_mux = (cfg_q.mode == MODE_D16_MUX) || (cfg_q.mode == MODE_D8_MUX);
    wire is_d8 = (cfg_q.mode == MODE_D8_MUX) || (cfg_q.mode == MODE_D8_DEMUX);
    wire accept = req_valid && req_ready && (st_q == ST_IDLE);
    wire go_ext = accept && (tgt == TGT_EXT);
    wire last_wait = (cnt_q == cfg_q.wait_cyc);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (go_ext) st_d = ST_ADDR;
            ST_ADDR: if (link_rise && cnt_q == PH_ADDR_CYC - 2'h1) st_d = ST_WAIT;
            ST_WAIT: if (link_rise && last_wait) st_d = ST_DATA;
            ST_DATA: if (link_rise && cnt_q == PH_DATA_CYC - 2'h1) st_d = ST_DONE;
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    wire [15:0] rd_word = is_d8 ? {8'h00, din_s2_q[7:0]} : din_s2_q;

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= ST_IDLE;
            acc_q <= '0;
            cfg_q <= '0;
            reg_q <= 3'h0;
            cnt_q <= 2'h0;
            nopipe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q != st_d) cnt_q <= 2'h0;
            else if (link_rise) cnt_q <= cnt_q + 2'h1;
            if (go_ext) begin
                acc_q <= req;
                cfg_q <= rcfg; // mode taken fresh each access
                reg_q <= region;
                nopipe_q <= is_xio;
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_trap <= 1'b0;
            rsp_bit_ok <= 1'b0;
            rsp_no_pipe <= 1'b0;
            address_port <= 16'h0000;
            segment_port <= 8'h00;
            data_port_o <= 16'h0000;
            data_port_oe <= 16'h0000;
            addr_latch_en <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= 5'h1f;
            lxb_sel <= 1'b0;
        end else begin
            // one access at a time; ready drops while an external cycle runs
            req_ready <= (st_d == ST_IDLE) && !go_ext;
            rsp_valid <= 1'b0;
            lxb_sel <= 1'b0;
            if (accept && tgt != TGT_EXT) begin
                rsp_valid <= 1'b1; // read and write data travel on separate paths
                rsp_trap <= (tgt == TGT_TRAP) || (tgt == TGT_FREG && freg_undef && !req.write);
                rsp_rdata <= (tgt == TGT_FREG && freg_undef) ? TRAP_CODE
                           : (tgt == TGT_LXB) ? lxb_rdata : int_rdata;
                rsp_bit_ok <= is_bitadr;
                rsp_no_pipe <= 1'b0;
                lxb_sel <= (tgt == TGT_LXB);
            end
            if (st_q == ST_ADDR) begin
                address_port <= acc_q.addr[15:0];
                segment_port <= acc_q.addr[23:16] & seg_mask;
                addr_latch_en <= 1'b1;
                if (cfg_q.cs_enable) cs_n <= ~(5'h01 << reg_q);
                data_port_o <= is_mux ? acc_q.addr[15:0] : 16'h0000;
                data_port_oe <= is_mux ? 16'hffff : 16'h0000;
            end
            if (st_q == ST_WAIT || st_q == ST_DATA) begin
                addr_latch_en <= 1'b0;
                rd_n <= acc_q.write;
                wr_n <= !acc_q.write;
                // byte access drives only the low lane
                data_port_o <= acc_q.write ? acc_q.wdata : 16'h0000;
                data_port_oe <= !acc_q.write ? 16'h0000
                              : (is_d8 || !acc_q.word) ? 16'h00ff : 16'hffff;
            end
            if (st_q == ST_DONE) begin
                rd_n <= 1'b1;
                wr_n <= 1'b1;
                cs_n <= 5'h1f;
                data_port_oe <= 16'h0000;
                rsp_valid <= 1'b1;
                rsp_trap <= 1'b0;
                rsp_bit_ok <= 1'b0;
                rsp_no_pipe <= nopipe_q;
                rsp_rdata <= acc_q.write ? 16'h0000 : rd_word;
            end
        end
    end

    // pin checks; a chip select shows one cycle after the address phase opens
    sequence seq_addr_phase;
        st_q == ST_ADDR;
    endsequence
    sequence seq_busy;
        st_q != ST_IDLE;
    endsequence
    sequence seq_take_win4;
        go_ext && hit[4] && rcfg.cs_enable;
    endsequence
    sequence seq_take_win2;
        go_ext && hit[2] && !hit[3] && !hit[4] && rcfg.cs_enable;
    endsequence
    sequence seq_take_default;
        go_ext && hit == 4'h0 && rcfg.cs_enable;
    endsequence
    sequence seq_read_data;
        st_q == ST_DATA && !acc_q.write;
    endsequence
    sequence seq_byte_write;
        st_q == ST_DATA && acc_q.write && (is_d8 || !acc_q.word);
    endsequence
    sequence seq_done_answer;
        rsp_valid && !rsp_trap && rd_n && wr_n && cs_n == 5'h1f;
    endsequence

    AST_CS_ONEHOT: assert property (@(posedge clk) disable iff (!rst_q)
        $countones(~cs_n) <= 1) else $error("more than one chip select");
    AST_TRAP_DATA: assert property (@(posedge clk) disable iff (!rst_q)
        accept && tgt == TGT_FREG && freg_undef && !req.write |=> rsp_rdata == TRAP_CODE)
        else $error("flash hole read without trap code");
    AST_WIN_PRIO: assert property (@(posedge clk) disable iff (!rst_q)
        seq_take_win4 |=> ##1 !cs_n[4]) else $error("window 4 lost priority");
    AST_WIN2_CS: assert property (@(posedge clk) disable iff (!rst_q)
        seq_take_win2 |=> ##1 !cs_n[2]) else $error("window 2 lost priority");
    AST_DEFAULT: assert property (@(posedge clk) disable iff (!rst_q)
        seq_take_default |=> ##1 !cs_n[0]) else $error("default region not used");
    AST_EXT_CYC: assert property (@(posedge clk) disable iff (!rst_q)
        go_ext |=> seq_addr_phase) else $error("external cycle not started");
    AST_SINGLE: assert property (@(posedge clk) disable iff (!rst_q)
        single_chip |-> !go_ext) else $error("external cycle in single chip");
    AST_SEGMASK: assert property (@(posedge clk) disable iff (!rst_q)
        seq_addr_phase |=> (segment_port & ~$past(seg_mask)) == 8'h00)
        else $error("inactive segment line driven");
    AST_MUX_ADDR: assert property (@(posedge clk) disable iff (!rst_q)
        st_q == ST_ADDR && is_mux |=> data_port_o == acc_q.addr[15:0])
        else $error("mux address phase wrong");
    AST_ADDR_LATCH: assert property (@(posedge clk) disable iff (!rst_q)
        seq_addr_phase |=> addr_latch_en) else $error("latch strobe missing in address phase");
    AST_RD_STROBE: assert property (@(posedge clk) disable iff (!rst_q)
        seq_read_data |=> !rd_n) else $error("read strobe high in data phase");
    AST_BYTE_LANE: assert property (@(posedge clk) disable iff (!rst_q)
        seq_byte_write |=> data_port_oe == 16'h00ff) else $error("byte write on high lane");
    AST_DONE: assert property (@(posedge clk) disable iff (!rst_q)
        st_q == ST_DONE |=> seq_done_answer) else $error("cycle end without clean answer");
    AST_BUSY: assert property (@(posedge clk) disable iff (!rst_q)
        seq_busy |-> !req_ready) else $error("request taken during external cycle");
    AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_q)
        accept && tgt == TGT_TRAP |=> rsp_valid && rsp_trap)
        else $error("reserved access not trapped");
endmodule

// ### ext_mem_model.sv
// external memory model answering read cycles on the data port
module ext_mem_model (
    input wire logic clk,
    input wire logic addr_latch_en,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] cs_n,
    input wire logic [15:0] address_port,
    input wire logic [15:0] data_port_o,
    input wire logic [15:0] data_port_oe,
    output logic [15:0] data_port_i,
    output logic [15:0] wr_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] addr_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] wr_q = 16'h0000;
    logic drive;
    assign drive = !rd_n && (cs_n != 5'h1f);
    // mux cycles show the address on the data port during the latch strobe
    always @(posedge clk) begin
        if (addr_latch_en) begin
            addr_q <= (data_port_oe != 16'h0000) ? data_port_o : address_port;
        end
        if (drive) begin
            last_q <= addr_q ^ 16'hc3a5;
        end
        // only the enabled lanes count, so a byte write shows zero above
        if (!wr_n && cs_n != 5'h1f) begin
            wr_q <= data_port_o & data_port_oe;
        end
    end
    assign wr_seen = wr_q;
    // released bus shows the inverse, so a stale sample cannot pass
    assign data_port_i = drive ? (addr_q ^ 16'hc3a5) : ~last_q;
endmodule

// ### tb_top.sv
// testbench: request sequences with expected answers
module tb_top;
    import bus_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic link_clk = 1'b0;
    logic req_valid = 1'b0;
    access_t req = '0;
    logic single_chip = 1'b0;
    logic [3:0] seg_lines = 4'h7;
    window_t win_cfg [1:4];
    region_cfg_t region_timing_cfg [0:4];
    logic [15:0] int_rdata = 16'h1234;
    logic [15:0] lxb_rdata = 16'h8765;
    logic req_ready, rsp_valid, rsp_trap, rsp_bit_ok, rsp_no_pipe, ale, rd_n, wr_n, lxb_sel;
    logic [15:0] rsp_rdata, address_port, data_port_o, data_port_oe, data_port_i;
    logic [7:0] segment_port;
    logic [4:0] cs_n, cs_seen;
    logic [15:0] x, wr_seen;
    int n_errors = 0;
    int cmp_count = 0;
    logic [23:0] win_addr [0:3] = '{24'h400010, 24'h400400, 24'h410010, 24'h410400};
    logic [4:0] win_cs [0:3] = '{5'h0f, 5'h17, 5'h1b, 5'h1d};

    always #25 clk = ~clk;
    // reference clock runs free like a real clock output
    always #200 link_clk = ~link_clk;

    ext_bus_address_decode i_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_trap(rsp_trap), .rsp_bit_ok(rsp_bit_ok), .rsp_no_pipe(rsp_no_pipe),
        .single_chip(single_chip), .seg_lines(seg_lines), .win_cfg(win_cfg),
        .region_timing_cfg(region_timing_cfg), .int_rdata(int_rdata),
        .lxb_rdata(lxb_rdata), .bus_reference_clock_out(link_clk),
        .address_port(address_port), .segment_port(segment_port),
        .data_port_o(data_port_o), .data_port_oe(data_port_oe), .data_port_i(data_port_i),
        .addr_latch_en(ale), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .lxb_sel(lxb_sel));

    ext_mem_model i_mem (.clk(clk), .addr_latch_en(ale), .rd_n(rd_n), .wr_n(wr_n),
        .cs_n(cs_n), .address_port(address_port), .data_port_o(data_port_o),
        .data_port_oe(data_port_oe), .data_port_i(data_port_i), .wr_seen(wr_seen));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access, request held until taken; cs_n low bits collected meanwhile
    task automatic access(input logic [23:0] a, input logic wr, input logic wd);
        int n;
        n = 0;
        @(negedge clk);
        req = '{addr: a, wdata: 16'hbeef, write: wr, word: wd};
        req_valid = 1'b1;
        // ready is a flop: settled here, and what the next rising edge sees
        while (req_ready !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk);
        end
        @(negedge clk);
        req_valid = 1'b0;
        cs_seen = 5'h1f;
        while (rsp_valid !== 1'b1 && n < 400) begin
            n++;
            cs_seen = cs_seen & cs_n;
            @(negedge clk);
        end
        if (n >= 400) begin
            $display("wait for answer ran out at %h", a);
            n_errors++;
            summarize();
        end
    endtask

    initial begin
        for (int k = 0; k <= 4; k++) begin
            region_timing_cfg[k] = '{mode: MODE_D16_DEMUX, wait_cyc: 2'h1, cs_enable: 1'b1};
        end
        for (int k = 1; k <= 4; k++) begin
            win_cfg[k] = '{base: 24'h400000, size_log: 4'h0, enable: 1'b0};
        end
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        // bench touches a defined register address and the undefined flash register hole at fff800
        access(24'h00fe00, 1'b0, 1'b1);
        check("register read", int_rdata, rsp_rdata);
        check("no peripheral select", 16'h0000, {15'h0000, lxb_sel});
        access(24'h00fd10, 1'b0, 1'b0);
        check("bit access", 16'h0001, {15'h0000, rsp_bit_ok});
        access(24'h200010, 1'b0, 1'b1);
        check("can read", lxb_rdata, rsp_rdata);
        check("peripheral select", 16'h0001, {15'h0000, lxb_sel});
        check("no bit access", 16'h0000, {15'h0000, rsp_bit_ok});
        access(24'hf80000, 1'b0, 1'b1);
        check("reserved trap", 16'h0001, {15'h0000, rsp_trap});
        access(24'hfff800, 1'b0, 1'b1);
        check("flash hole", TRAP_CODE, rsp_rdata);
        single_chip = 1'b1;
        access(24'h012468, 1'b0, 1'b1);
        check("single chip trap", 16'h0001, {15'h0000, rsp_trap});
        single_chip = 1'b0;
        $display("test internal targets done");
        access(24'h012468, 1'b0, 1'b1);
        check("external read", 16'h2468 ^ 16'hc3a5, rsp_rdata);
        check("default select", 16'h0000, {15'h0000, cs_seen[0]});
        check("address port", 16'h2468, address_port);
        check("segment port", 16'h0001, {8'h00, segment_port});
        check("memory pipelined", 16'h0000, {15'h0000, rsp_no_pipe});
        access(24'h012468, 1'b1, 1'b1);
        check("word write", 16'hbeef, wr_seen);
        access(24'h012468, 1'b1, 1'b0);
        check("byte write", 16'h00ef, wr_seen);
        access(24'h200800, 1'b0, 1'b1);
        check("io no pipeline", 16'h0001, {15'h0000, rsp_no_pipe});
        seg_lines = 4'h1;
        access(24'h1e2468, 1'b0, 1'b1);
        check("one segment line", 16'h0000, {8'h00, segment_port});
        seg_lines = 4'hf;
        access(24'h8e2468, 1'b0, 1'b1);
        check("segment lines capped", 16'h000e, {8'h00, segment_port});
        seg_lines = 4'h7;
        $display("test external default done");
        // pair 3/4 and pair 1/2 share a base, the smaller window on top
        win_cfg[3] = '{base: 24'h400000, size_log: 4'hc, enable: 1'b1};
        win_cfg[4] = '{base: 24'h400000, size_log: 4'h8, enable: 1'b1};
        win_cfg[1] = '{base: 24'h410000, size_log: 4'hc, enable: 1'b1};
        win_cfg[2] = '{base: 24'h410000, size_log: 4'h8, enable: 1'b1};
        for (int k = 0; k < 4; k++) begin
            access(win_addr[k], 1'b0, 1'b1);
            check("window select", {11'h000, win_cs[k]}, {11'h000, cs_seen});
        end
        $display("test windows done");
        for (int k = 0; k < 4; k++) begin
            region_timing_cfg[0].mode = bus_mode_t'(k);
            access(24'h013c5a, 1'b0, 1'b1);
            x = 16'h3c5a ^ 16'hc3a5;
            if (k >= 2) begin
                x = {8'h00, x[7:0]};
            end
            check("mode read", x, rsp_rdata);
        end
        $display("test bus modes done");
        summarize();
    end
endmodule
